// ==== rtl/tmc_consts.svh ====
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TMC_OFS_READBACK 6'h01
`define TMC_OFS_COMMAND  6'h02

// ----------------------------------------
// spi access codes
// ----------------------------------------
`define TMC_ACC_WRITE 2'h3

// ----------------------------------------
// state command values
// ----------------------------------------
`define TMC_CMD_NOP         8'h00
`define TMC_CMD_TX_START    8'h02
`define TMC_CMD_FORCE_IDLE  8'h03
`define TMC_CMD_LISTEN      8'h06
`define TMC_CMD_IDLE        8'h08
`define TMC_CMD_SYNTH_READY 8'h09

// ----------------------------------------
// timing
// ----------------------------------------
`define TMC_CLK_PERIOD_NS  5
`define TMC_PON_SETTLE_NS  128000
`define TMC_PON_SETTLE_CYC ((`TMC_PON_SETTLE_NS + `TMC_CLK_PERIOD_NS - 1) / `TMC_CLK_PERIOD_NS)
`define TMC_REG_SETTLE_NS  16000
`define TMC_REG_SETTLE_CYC ((`TMC_REG_SETTLE_NS + `TMC_CLK_PERIOD_NS - 1) / `TMC_CLK_PERIOD_NS)
`define TMC_CLKOUT_HALF_NS 500
`define TMC_CLKOUT_HALF_CYC (`TMC_CLKOUT_HALF_NS / `TMC_CLK_PERIOD_NS)

`endif

// ==== rtl/tmc_pkg.sv ====
package tmc_pkg;

  // ----------------------------------------
  // operating states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_POWER_ON    = 3'b000,
    ST_SLEEP       = 3'b001,
    ST_IDLE        = 3'b010,
    ST_SYNTH_READY = 3'b011,
    ST_LISTEN      = 3'b100,
    ST_BUSY_RX     = 3'b101,
    ST_BUSY_TX     = 3'b110
  } tmc_state_t;

  // ----------------------------------------
  // core clock domain state
  // ----------------------------------------
  typedef struct packed {
    tmc_state_t  state;
    logic [15:0] cnt;
    logic        settled;
    logic        regDone;
    logic        pending;
    logic [7:0]  cmdReg;
    logic [7:0]  readback;
    logic        pinS0;
    logic        pinS1;
    logic        pinPrev;
    logic        rstS0;
    logic        rstS1;
    logic        togS0;
    logic        togS1;
    logic        togSeen;
    logic        lockPrev;
    logic        spiClear;
    logic [7:0]  divCnt;
    logic        clkOut;
    logic        pullEnable;
    logic        oscEnable;
    logic        regulatorEnable;
    logic        synthEnable;
    logic        rxEnable;
    logic        txEnable;
    logic        irq;
    logic        frameAbort;
  } tmc_core_t;

  // ----------------------------------------
  // spi clock domain state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  shift;
    logic [5:0]  addr;
    logic        isWrite;
    logic [7:0]  wrData;
    logic        wrToggle;
    logic [7:0]  rdShift;
    logic [15:0] rbS0;
    logic [15:0] rbS1;
  } tmc_spi_t;

  typedef struct packed {
    logic miso;
    logic misoOe;
  } tmc_out_t;

endpackage

// ==== rtl/tmc_mode_controller.sv ====
`timescale 1ns/1ps
`include "tmc_consts.svh"

// Function
// - pins and spi command change operating state
// - current state readable at readback register
// - reset pin forces idle, except power-on
// - forced idle aborts frame immediately
// - ordinary idle waits until frame ends
// - clock output starts after oscillator settle delay
// - input pulls active only in power-on
// - idle or forced idle write leaves power-on
// - internal power-on reset loads all defaults
// - sleep only from idle with pin high
// - no spi write reaches sleep
// - pin low wakes to idle, registers kept
// - reset pin in sleep restores defaults, idle
// - idle keeps spi, oscillator, clock output running
// - regulator first, synthesizer after settling
// - synthesizer lock raises interrupt output
// - listen command accepted before lock
module tmc_mode_controller
  import tmc_pkg::*;
#(
  parameter int PON_SETTLE_CYCLES = `TMC_PON_SETTLE_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sleepTransmitPin,
  input  wire logic resetPinN,
  input  wire logic sclk,
  input  wire logic selN,
  input  wire logic mosi,
  output logic      miso,
  output logic      misoOe,
  input  wire logic synthLock,
  input  wire logic preambleDetect,
  input  wire logic frameEnd,
  output logic      controllerClockOut,
  output logic      pullEnable,
  output logic      oscEnable,
  output logic      regulatorEnable,
  output logic      synthEnable,
  output logic      rxEnable,
  output logic      txEnable,
  output logic      irq,
  output logic      frameAbort
);

  localparam logic [15:0] PonCyc = 16'(PON_SETTLE_CYCLES);
  localparam logic [15:0] RegCyc = 16'(`TMC_REG_SETTLE_CYC);
  localparam logic [7:0]  HalfCyc = 8'(`TMC_CLKOUT_HALF_CYC);

  tmc_core_t  core_reg;
  tmc_core_t  core_next;
  tmc_spi_t   spi_reg;
  tmc_spi_t   spi_next;
  logic [3:0] bitCnt_reg;
  tmc_out_t   out_reg;
  tmc_out_t   out_next;

  logic       wrEv;
  logic [7:0] cmd;
  logic       pinHigh;
  logic       pinRise;
  logic       lockRise;
  logic       pend;
  logic       clkOutOn;
  logic [7:0] inByte;

  // ----------------------------------------
  // core state machine
  // ----------------------------------------
  always_comb begin
    core_next = core_reg;
    wrEv      = core_reg.togS1 ^ core_reg.togSeen;
    cmd       = spi_reg.wrData;
    pinHigh   = core_reg.pinS1;
    pinRise   = core_reg.pinS1 & ~core_reg.pinPrev;
    lockRise  = synthLock & ~core_reg.lockPrev & core_reg.synthEnable;
    pend      = core_reg.pending | (wrEv && cmd == `TMC_CMD_IDLE);
    clkOutOn  = 1'b0;

    core_next.pinS0      = sleepTransmitPin;
    core_next.pinS1      = core_reg.pinS0;
    core_next.pinPrev    = core_reg.pinS1;
    core_next.rstS0      = resetPinN;
    core_next.rstS1      = core_reg.rstS0;
    core_next.togS0      = spi_reg.wrToggle;
    core_next.togS1      = core_reg.togS0;
    core_next.togSeen    = core_reg.togS1;
    core_next.lockPrev   = synthLock;
    core_next.spiClear   = 1'b0;
    core_next.frameAbort = 1'b0;

    if (wrEv) begin
      core_next.cmdReg = cmd;
    end
    if (core_reg.cnt != 16'h0000) begin
      core_next.cnt = core_reg.cnt - 16'h0001;
    end

    case (core_reg.state)
      ST_POWER_ON: begin
        if (core_reg.cnt == 16'h0000) begin
          core_next.settled = 1'b1;
        end
        if (wrEv && core_reg.settled &&
            (cmd == `TMC_CMD_IDLE || cmd == `TMC_CMD_FORCE_IDLE)) begin
          core_next.state = ST_IDLE;
        end
      end
      ST_SLEEP: begin
        if (!pinHigh) begin
          core_next.state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (pinHigh) begin
          core_next.state = ST_SLEEP;
        end else if (wrEv && (cmd == `TMC_CMD_SYNTH_READY || cmd == `TMC_CMD_LISTEN)) begin
          core_next.state   = (cmd == `TMC_CMD_LISTEN) ? ST_LISTEN : ST_SYNTH_READY;
          core_next.cnt     = RegCyc;
          core_next.regDone = 1'b0;
        end
      end
      ST_SYNTH_READY: begin
        if (wrEv) begin
          case (cmd)
            `TMC_CMD_IDLE,
            `TMC_CMD_FORCE_IDLE: core_next.state = ST_IDLE;
            `TMC_CMD_LISTEN:     core_next.state = ST_LISTEN;
            `TMC_CMD_TX_START:   core_next.state = ST_BUSY_TX;
            default:             core_next.state = ST_SYNTH_READY;
          endcase
        end else if (pinRise && core_reg.regDone) begin
          core_next.state = ST_BUSY_TX;
        end
      end
      ST_LISTEN: begin
        if (wrEv && (cmd == `TMC_CMD_IDLE || cmd == `TMC_CMD_FORCE_IDLE)) begin
          core_next.state = ST_IDLE;
        end else if (wrEv && cmd == `TMC_CMD_SYNTH_READY) begin
          core_next.state = ST_SYNTH_READY;
        end else if (preambleDetect && core_reg.regDone) begin
          core_next.state = ST_BUSY_RX;
        end
      end
      ST_BUSY_RX,
      ST_BUSY_TX: begin
        if (wrEv && cmd == `TMC_CMD_FORCE_IDLE) begin
          core_next.state      = ST_IDLE;
          core_next.pending    = 1'b0;
          core_next.frameAbort = 1'b1;
        end else if (frameEnd) begin
          core_next.pending = 1'b0;
          if (pend) begin
            core_next.state = ST_IDLE;
          end else if (core_reg.state == ST_BUSY_RX) begin
            core_next.state = ST_LISTEN;
          end else begin
            core_next.state = ST_SYNTH_READY;
          end
        end else begin
          core_next.pending = pend;
        end
      end
      default: begin
        core_next.state = ST_POWER_ON;
      end
    endcase

    if (core_next.state == ST_IDLE) begin
      core_next.regDone = 1'b0;
    end else if (core_reg.state >= ST_SYNTH_READY && core_reg.cnt == 16'h0000) begin
      core_next.regDone = 1'b1;
    end

    if (wrEv) begin
      core_next.irq = 1'b0;
    end
    if (lockRise) begin
      core_next.irq = 1'b1;
    end

    if (!core_reg.rstS1 && core_reg.state != ST_POWER_ON) begin
      core_next.state   = ST_IDLE;
      core_next.cmdReg  = `TMC_CMD_NOP;
      core_next.pending = 1'b0;
      core_next.irq     = 1'b0;
      core_next.regDone = 1'b0;
      core_next.cnt     = 16'h0000;
    end

    core_next.pullEnable      = core_next.state == ST_POWER_ON;
    core_next.oscEnable       = core_next.state != ST_SLEEP;
    core_next.regulatorEnable = core_next.state >= ST_SYNTH_READY;
    core_next.synthEnable     = core_next.regulatorEnable && core_next.regDone;
    core_next.rxEnable        = core_next.state == ST_LISTEN || core_next.state == ST_BUSY_RX;
    core_next.txEnable        = core_next.state == ST_BUSY_TX;
    core_next.readback        = {5'h00, core_next.state};

    clkOutOn = core_next.oscEnable && (core_next.state != ST_POWER_ON || core_next.settled);
    if (!clkOutOn) begin
      core_next.clkOut = 1'b0;
      core_next.divCnt = 8'h00;
    end else if (core_reg.divCnt == 8'h00) begin
      core_next.clkOut = ~core_reg.clkOut;
      core_next.divCnt = HalfCyc - 8'h01;
    end else begin
      core_next.divCnt = core_reg.divCnt - 8'h01;
    end

    if (!rst_n) begin
      core_next            = '0;
      core_next.state      = ST_POWER_ON;
      core_next.cnt        = PonCyc;
      core_next.cmdReg     = `TMC_CMD_NOP;
      core_next.rstS0      = 1'b1;
      core_next.rstS1      = 1'b1;
      core_next.spiClear   = 1'b1;
      core_next.pullEnable = 1'b1;
      core_next.oscEnable  = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    core_reg <= core_next;
  end

  // ----------------------------------------
  // spi slave on the link clock
  // ----------------------------------------
  always_comb begin
    spi_next       = spi_reg;
    inByte         = {spi_reg.shift[6:0], mosi};
    spi_next.rbS0  = {core_reg.cmdReg, core_reg.readback};
    spi_next.rbS1  = spi_reg.rbS0;
    spi_next.shift = inByte;
    spi_next.rdShift = {spi_reg.rdShift[6:0], 1'b0};
    if (bitCnt_reg == 4'h7) begin
      spi_next.isWrite = inByte[7:6] == `TMC_ACC_WRITE;
      spi_next.addr    = inByte[5:0];
      case (inByte[5:0])
        `TMC_OFS_READBACK: spi_next.rdShift = spi_reg.rbS1[7:0];
        `TMC_OFS_COMMAND:  spi_next.rdShift = spi_reg.rbS1[15:8];
        default:           spi_next.rdShift = 8'h00;
      endcase
    end
    if (bitCnt_reg == 4'hF && spi_reg.isWrite && spi_reg.addr == `TMC_OFS_COMMAND) begin
      spi_next.wrData   = inByte;
      spi_next.wrToggle = ~spi_reg.wrToggle;
    end
  end

  always_ff @(posedge sclk or posedge core_reg.spiClear) begin
    if (core_reg.spiClear) begin
      spi_reg <= '0;
    end else begin
      spi_reg <= spi_next;
    end
  end

  always_ff @(posedge sclk or posedge selN) begin
    if (selN) begin
      bitCnt_reg <= 4'h0;
    end else begin
      bitCnt_reg <= bitCnt_reg + 4'h1;
    end
  end

  always_comb begin
    out_next.miso   = spi_reg.rdShift[7];
    out_next.misoOe = 1'b1;
  end

  always_ff @(negedge sclk or posedge selN) begin
    if (selN) begin
      out_reg <= '0;
    end else begin
      out_reg <= out_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign miso               = out_reg.miso;
  assign misoOe             = out_reg.misoOe;
  assign controllerClockOut = core_reg.clkOut;
  assign pullEnable         = core_reg.pullEnable;
  assign oscEnable          = core_reg.oscEnable;
  assign regulatorEnable    = core_reg.regulatorEnable;
  assign synthEnable        = core_reg.synthEnable;
  assign rxEnable           = core_reg.rxEnable;
  assign txEnable           = core_reg.txEnable;
  assign irq                = core_reg.irq;
  assign frameAbort         = core_reg.frameAbort;

endmodule // tmc_mode_controller

// ==== sim/tmc_mode_controller_sva.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module tmc_mode_controller_sva #(
  parameter int PON_SETTLE_CYCLES = 50
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sleepTransmitPin,
  input wire logic resetPinN,
  input wire logic selN,
  input wire logic misoOe,
  input wire logic synthLock,
  input wire logic controllerClockOut,
  input wire logic pullEnable,
  input wire logic oscEnable,
  input wire logic regulatorEnable,
  input wire logic synthEnable,
  input wire logic rxEnable,
  input wire logic txEnable,
  input wire logic irq,
  input wire logic frameAbort
);
  logic [15:0] ponCnt_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) ponCnt_reg <= 16'h0000;
    else if (ponCnt_reg != 16'hFFFF) ponCnt_reg <= ponCnt_reg + 16'h0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  settle_wait_a: assert property (ponCnt_reg < PON_SETTLE_CYCLES |-> !controllerClockOut)
    else $error("clock out too early");
  pull_pon_a: assert property (pullEnable |-> oscEnable && !regulatorEnable && !rxEnable && !txEnable)
    else $error("pulls outside power-on");
  sleep_gate_a: assert property (!oscEnable |-> !regulatorEnable && !pullEnable && !rxEnable && !controllerClockOut)
    else $error("sleep not stopped");
  sleep_entry_a: assert property ($fell(oscEnable) |-> $past(sleepTransmitPin) && !$past(regulatorEnable) && !$past(pullEnable))
    else $error("bad sleep entry");
  wake_up_a: assert property (!oscEnable && !sleepTransmitPin |-> ##[1:6] oscEnable)
    else $error("no wake");
  pin_reset_a: assert property ((!resetPinN && !pullEnable) [*6] |-> oscEnable && !regulatorEnable && !irq)
    else $error("reset pin ignored");
  frame_abort_a: assert property (frameAbort |-> $past(rxEnable || txEnable) ##1 (!rxEnable && !txEnable))
    else $error("bad abort");
  reg_first_a: assert property (synthEnable |-> regulatorEnable && $past(regulatorEnable))
    else $error("synth before regulator");
  lock_irq_a: assert property ($rose(irq) |-> $past(synthLock) && $past(synthEnable))
    else $error("irq without lock");
  clk_run_a: assert property (oscEnable && !pullEnable && $changed(controllerClockOut) |-> ##[1:101] ($changed(controllerClockOut) || !oscEnable))
    else $error("clock out stalled");
  oe_release_a: assert property ($rose(selN) |-> !misoOe)
    else $error("miso still driven after deselect");
  cover property ($rose(irq));
  cover property ($rose(txEnable));
  cover property (frameAbort);
  cover property ($fell(oscEnable));
endmodule // tmc_mode_controller_sva

bind tmc_mode_controller tmc_mode_controller_sva #(.PON_SETTLE_CYCLES(PON_SETTLE_CYCLES)) u_sva (.*);

// ==== sim/tmc_host_model.sv ====
`timescale 1ns/1ps
`include "tmc_consts.svh"
// ----------------------------------------
// host controller model
// ----------------------------------------
module tmc_host_model (
  input  wire logic clk,
  input  wire logic miso,
  output logic      sclk,
  output logic      selN,
  output logic      mosi,
  output logic      sleepTransmitPin,
  output logic      resetPinN
);
  initial begin
    sclk = 1'h0;
    selN = 1'h1;
    mosi = 1'h0;
    sleepTransmitPin = 1'h0;
    resetPinN = 1'h1;
  end
  task automatic xfer(input logic [15:0] sh, output logic [7:0] r);
    #37.3 selN = 1'h0;
    for (int i = 15; i >= 0; i--) begin
      mosi = sh[i];
      #80 sclk = 1'h1;
      if (i < 8) r[i] = miso;
      #80 sclk = 1'h0;
    end
    #80 selN = 1'h1;
    mosi = ~mosi;
    #320;
  endtask
  task automatic wr(input logic [7:0] d);
    logic [7:0] r;
    xfer({`TMC_ACC_WRITE, `TMC_OFS_COMMAND, d}, r);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] r);
    xfer({2'h0, a, 8'h00}, r);
  endtask
  task automatic pins(input logic s, input logic rn);
    @(posedge clk);
    sleepTransmitPin <= s;
    resetPinN <= rn;
  endtask
endmodule // tmc_host_model

// ==== sim/tmc_mode_controller_test.sv ====
`timescale 1ns/1ps
`include "tmc_consts.svh"
// ----------------------------------------
// mode controller bench
// ----------------------------------------
module tmc_mode_controller_test
  import tmc_pkg::*;
;
  logic       clk, rst_n, sclk, selN, mosi, miso, misoOe, sleepTransmitPin, resetPinN;
  logic       synthLock, preambleDetect, frameEnd, controllerClockOut, pullEnable, oscEnable;
  logic       regulatorEnable, synthEnable, rxEnable, txEnable, irq, frameAbort;
  logic [7:0] r;
  int         err_total, total_checks, aborts, n;
  tmc_mode_controller #(.PON_SETTLE_CYCLES(50)) u_dut (.*);
  tmc_host_model u_host (.*);
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) if (frameAbort === 1'h1) aborts++;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic st(input tmc_state_t s);
    u_host.rd(`TMC_OFS_READBACK, r);
    check(r, {5'h00, s});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_pon;
    n = 0;
    while (controllerClockOut !== 1'h1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    check(8'(n >= 50 && n < 400), 8'h01);
    check({7'h00, pullEnable}, 8'h01);
    st(ST_POWER_ON);
    u_host.pins(1'h0, 1'h0);
    cyc(10);
    st(ST_POWER_ON);
    u_host.pins(1'h0, 1'h1);
    cyc(10);
    u_host.wr(`TMC_CMD_LISTEN);
    st(ST_POWER_ON);
    u_host.wr(`TMC_CMD_IDLE);
    st(ST_IDLE);
    check({7'h00, pullEnable}, 8'h00);
  endtask
  task automatic t_sleep;
    u_host.wr(8'h01);
    st(ST_IDLE);
    u_host.pins(1'h1, 1'h1);
    cyc(10);
    check({7'h00, oscEnable}, 8'h00);
    u_host.pins(1'h0, 1'h1);
    cyc(10);
    check({7'h00, oscEnable}, 8'h01);
    u_host.rd(`TMC_OFS_COMMAND, r);
    check(r, 8'h01);
    u_host.pins(1'h1, 1'h1);
    cyc(10);
    u_host.pins(1'h1, 1'h0);
    cyc(10);
    check({7'h00, oscEnable}, 8'h01);
    u_host.pins(1'h0, 1'h1);
    u_host.rd(`TMC_OFS_COMMAND, r);
    check(r, 8'h00);
    st(ST_IDLE);
  endtask
  task automatic t_rx;
    u_host.wr(`TMC_CMD_SYNTH_READY);
    check({6'h00, regulatorEnable, synthEnable}, 8'h02);
    u_host.wr(`TMC_CMD_LISTEN);
    st(ST_LISTEN);
    cyc(3300);
    check({7'h00, synthEnable}, 8'h01);
    @(posedge clk) synthLock <= 1'h1;
    cyc(4);
    check({7'h00, irq}, 8'h01);
    @(posedge clk) preambleDetect <= 1'h1;
    @(posedge clk) preambleDetect <= 1'h0;
    u_host.wr(`TMC_CMD_IDLE);
    st(ST_BUSY_RX);
    @(posedge clk) frameEnd <= 1'h1;
    @(posedge clk) frameEnd <= 1'h0;
    st(ST_IDLE);
    @(posedge clk) synthLock <= 1'h0;
  endtask
  task automatic t_abort;
    u_host.wr(`TMC_CMD_LISTEN);
    cyc(3300);
    @(posedge clk) preambleDetect <= 1'h1;
    @(posedge clk) preambleDetect <= 1'h0;
    st(ST_BUSY_RX);
    @(posedge clk) frameEnd <= 1'h1;
    @(posedge clk) frameEnd <= 1'h0;
    st(ST_LISTEN);
    @(posedge clk) preambleDetect <= 1'h1;
    @(posedge clk) preambleDetect <= 1'h0;
    n = aborts;
    u_host.wr(`TMC_CMD_FORCE_IDLE);
    check(8'(aborts - n), 8'h01);
    check({7'h00, rxEnable}, 8'h00);
    st(ST_IDLE);
  endtask
  task automatic t_tx;
    u_host.wr(`TMC_CMD_SYNTH_READY);
    cyc(3300);
    check({7'h00, txEnable}, 8'h00);
    u_host.pins(1'h1, 1'h1);
    cyc(10);
    check({7'h00, txEnable}, 8'h01);
    st(ST_BUSY_TX);
    @(posedge clk) frameEnd <= 1'h1;
    @(posedge clk) frameEnd <= 1'h0;
    u_host.pins(1'h0, 1'h1);
    st(ST_SYNTH_READY);
    u_host.wr(`TMC_CMD_TX_START);
    check({7'h00, txEnable}, 8'h01);
    n = aborts;
    u_host.wr(`TMC_CMD_FORCE_IDLE);
    check(8'(aborts - n), 8'h01);
    check({7'h00, txEnable}, 8'h00);
    st(ST_IDLE);
  endtask
  initial begin
    rst_n = 1'h0;
    synthLock = 1'h0;
    preambleDetect = 1'h0;
    frameEnd = 1'h0;
    err_total = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    t_pon;
    t_sleep;
    t_rx;
    t_abort;
    t_tx;
    stop_test;
  end
  initial begin
    #400000;
    err_total++;
    stop_test;
  end
endmodule // tmc_mode_controller_test
